//--- design/opsm_output_pin_select_mux.sv
// Output pin select mux: three remappable pins with selection registers on Avalon-MM
// Design notes
// - Pin drive is registered, so a new code reaches its pin one clock after the
//   write edge, and a peripheral level reaches the pin one clock after it changes.
// - Code zero and reserved codes both hand the pin back to the port latch and its
//   output enable; no remappable peripheral can then disturb the pin.
// - Only the low nibble of each register is stored; the upper bits read as zero
//   whatever software writes, so a wide write cannot select a hidden code.
// - Byte lane 0 gates every write, since only that lane holds implemented bits.
// - Writes complete with no wait state; reads hold waitrequest for one cycle so
//   read data and response always come from flip-flops.
// - Registers of pins absent on the chosen variant are unmapped: writes are
//   dropped, reads return zero with an error response, and the pin stays off.
// - The variant is fixed at build time, so the decode folds to constants.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
module opsm_output_pin_select_mux #(
    parameter opsm_pkg::opsm_variant_e VARIANT = opsm_pkg::OPSM_VAR_100_USB
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // Peripheral outputs, first group
    input wire logic uart3_request_to_send_i,
    input wire logic uart4_transmit_i,
    input wire logic reference_clock_output_i,
    input wire logic spi1_slave_select_i,
    input wire logic spi1_serial_out_i,
    input wire logic compare_output_five_i,
    input wire logic comparator_one_output_i,
    // Peripheral outputs, second group
    input wire logic uart2_request_to_send_i,
    input wire logic uart5_transmit_i,
    input wire logic spi2_slave_select_i,
    input wire logic compare_output_two_i,
    input wire logic compare_output_one_i,
    // Port latch values and directions, index 0 pin E5, 1 pin E8, 2 pin E9
    input wire logic [2:0] port_latch_i,
    input wire logic [2:0] port_oe_i,
    // Pin drive
    output logic [2:0] pin_out_o,
    output logic [2:0] pin_oe_o
);

    // ------------------------------------------------------------
    // Variant decode
    // ------------------------------------------------------------
    // Pin E5: always present; E8 and E9 only on 100-pin parts
    logic [2:0] pin_present;
    assign pin_present[0] = 1'b1;
    assign pin_present[1] = (VARIANT == opsm_pkg::OPSM_VAR_100_GP) ||
                            (VARIANT == opsm_pkg::OPSM_VAR_100_USB);
    assign pin_present[2] = (VARIANT == opsm_pkg::OPSM_VAR_100_GP) ||
                            (VARIANT == opsm_pkg::OPSM_VAR_100_USB);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [3:0] sel_q [3];
    logic rd_ack_q;
    logic [31:0] rdata_q;
    logic [1:0] resp_q;
    logic [1:0] hit_idx;
    logic hit;

    // Address decode; absent pins are unmapped
    // An address matches only when its pin exists on this variant, so a
    // missing register behaves exactly like any other unmapped address.
    always_comb begin
        hit = 1'b0;
        hit_idx = 2'h0;
        if (avs_address_i == opsm_pkg::OPSM_PIN_E5_OFFSET && pin_present[0]) begin
            hit = 1'b1;
            hit_idx = 2'h0;
        end else if (avs_address_i == opsm_pkg::OPSM_PIN_E8_OFFSET && pin_present[1]) begin
            hit = 1'b1;
            hit_idx = 2'h1;
        end else if (avs_address_i == opsm_pkg::OPSM_PIN_E9_OFFSET && pin_present[2]) begin
            hit = 1'b1;
            hit_idx = 2'h2;
        end
    end

    // Writes take effect at once; reads answer one cycle later
    assign avs_waitrequest_o = avs_read_i && !rd_ack_q;
    assign avs_readdata_o = rdata_q;
    assign avs_response_o = resp_q;

    // Read pipeline: data and response registered
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            resp_q <= 2'h0;
        end else begin
            rd_ack_q <= avs_read_i && !rd_ack_q;
            if (avs_read_i && !rd_ack_q) begin
                if (hit) begin
                    rdata_q <= {28'h0000000, sel_q[hit_idx]};
                    resp_q <= 2'h0;
                end else begin
                    rdata_q <= opsm_pkg::OPSM_UNMAPPED_RDATA;
                    resp_q <= 2'h2;
                end
            end else if (avs_write_i) begin
                resp_q <= hit ? 2'h0 : 2'h2;
            end
        end
    end

    // Selection registers, low nibble only
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                sel_q[i] <= opsm_pkg::OPSM_SEL_RESET[3:0];
            end
        end else if (avs_write_i && hit && avs_byteenable_i[0]) begin
            sel_q[hit_idx] <= avs_writedata_i[opsm_pkg::OPSM_SEL_LSB +: opsm_pkg::OPSM_SEL_W];
        end
    end

    // ------------------------------------------------------------
    // Output mux
    // ------------------------------------------------------------
    // E5 is in the first group, E8 in the second, E9 in the first
    logic [2:0] mux_val;
    logic [2:0] mux_valid;

    function automatic logic [1:0] opsm_group1(input logic [3:0] code, input logic [6:0] src);
        logic [1:0] r;
        r = 2'b00;
        case (code)
            opsm_pkg::OPSM_G1_UART3_RTS: r = {1'b1, src[0]};
            opsm_pkg::OPSM_G1_UART4_TX: r = {1'b1, src[1]};
            opsm_pkg::OPSM_G1_REFCLK: r = {1'b1, src[2]};
            opsm_pkg::OPSM_G1_SPI1_SS: r = {1'b1, src[3]};
            opsm_pkg::OPSM_G1_SPI1_SDO: r = {1'b1, src[4]};
            opsm_pkg::OPSM_G1_OC5: r = {1'b1, src[5]};
            opsm_pkg::OPSM_G1_CMP1: r = {1'b1, src[6]};
            default: r = 2'b00;
        endcase
        return r;
    endfunction

    function automatic logic [1:0] opsm_group2(input logic [3:0] code, input logic [4:0] src);
        logic [1:0] r;
        r = 2'b00;
        case (code)
            opsm_pkg::OPSM_G2_UART2_RTS: r = {1'b1, src[0]};
            opsm_pkg::OPSM_G2_UART5_TX: r = {1'b1, src[1]};
            opsm_pkg::OPSM_G2_SPI2_SS: r = {1'b1, src[2]};
            opsm_pkg::OPSM_G2_OC2: r = {1'b1, src[3]};
            opsm_pkg::OPSM_G2_OC1: r = {1'b1, src[4]};
            default: r = 2'b00;
        endcase
        return r;
    endfunction

    logic [6:0] g1_src;
    logic [4:0] g2_src;
    assign g1_src = {comparator_one_output_i, compare_output_five_i, spi1_serial_out_i, spi1_slave_select_i,
                     reference_clock_output_i, uart4_transmit_i, uart3_request_to_send_i};
    assign g2_src = {compare_output_one_i, compare_output_two_i, spi2_slave_select_i, uart5_transmit_i,
                     uart2_request_to_send_i};

    // Peripheral selection per pin
    always_comb begin
        {mux_valid[0], mux_val[0]} = opsm_group1(sel_q[0], g1_src);
        {mux_valid[1], mux_val[1]} = opsm_group2(sel_q[1], g2_src);
        {mux_valid[2], mux_val[2]} = opsm_group1(sel_q[2], g1_src);
    end

    // Registered pin drive: peripheral wins over port latch
    // Absent pins are held off so nothing leaks onto a bond pad that the
    // smaller packages do not have. A selected peripheral always enables the
    // pin driver; otherwise the port's own direction decides.
    // Registering here costs one cycle of latency but keeps the pin free of
    // glitches while a code or a peripheral level changes.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_out_o <= 3'h0;
            pin_oe_o <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!pin_present[i]) begin
                    pin_out_o[i] <= 1'b0;
                    pin_oe_o[i] <= 1'b0;
                end else if (mux_valid[i]) begin
                    pin_out_o[i] <= mux_val[i];
                    pin_oe_o[i] <= 1'b1;
                end else begin
                    pin_out_o[i] <= port_latch_i[i];
                    pin_oe_o[i] <= port_oe_i[i];
                end
            end
        end
    end

endmodule

//--- design/opsm_pkg.sv
// Package of register offsets, field layout and selection codes for the output pin select mux
package opsm_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] OPSM_PIN_E5_OFFSET = 16'hFC14;
    localparam logic [15:0] OPSM_PIN_E8_OFFSET = 16'hFC20;
    localparam logic [15:0] OPSM_PIN_E9_OFFSET = 16'hFC24;
    localparam logic [31:0] OPSM_SEL_RESET = 32'h00000000;
    localparam int OPSM_SEL_LSB = 0;
    localparam int OPSM_SEL_W = 4;
    localparam logic [31:0] OPSM_UNMAPPED_RDATA = 32'h00000000;

    // ------------------------------------------------------------
    // Selection codes, first pin group
    // ------------------------------------------------------------
    localparam logic [3:0] OPSM_CODE_NONE = 4'h0;
    localparam logic [3:0] OPSM_G1_UART3_RTS = 4'h1;
    localparam logic [3:0] OPSM_G1_UART4_TX = 4'h2;
    localparam logic [3:0] OPSM_G1_REFCLK = 4'h3;
    localparam logic [3:0] OPSM_G1_SPI1_SS = 4'h7;
    localparam logic [3:0] OPSM_G1_SPI1_SDO = 4'h8;
    localparam logic [3:0] OPSM_G1_OC5 = 4'hB;
    localparam logic [3:0] OPSM_G1_CMP1 = 4'hD;

    // ------------------------------------------------------------
    // Selection codes, second pin group
    // ------------------------------------------------------------
    localparam logic [3:0] OPSM_G2_UART2_RTS = 4'h1;
    localparam logic [3:0] OPSM_G2_UART5_TX = 4'h4;
    localparam logic [3:0] OPSM_G2_SPI2_SS = 4'h6;
    localparam logic [3:0] OPSM_G2_OC2 = 4'hB;
    localparam logic [3:0] OPSM_G2_OC1 = 4'hC;

    // Device variants
    typedef enum logic [3:0] {
        OPSM_VAR_64_GP = 4'b0001,
        OPSM_VAR_64_USB = 4'b0010,
        OPSM_VAR_100_GP = 4'b0100,
        OPSM_VAR_100_USB = 4'b1000
    } opsm_variant_e;
endpackage

//--- tb/opsm_asserts.sv
// Checker of the bus handshake and of pin E5 routing
`timescale 1ns/10ps
module opsm_asserts (
    // Clock, reset and bus
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [1:0] avs_response_o,
    // Source and pins
    input wire logic uart3_request_to_send_i,
    input wire logic [2:0] port_latch_i,
    input wire logic [2:0] port_oe_i,
    input wire logic [2:0] pin_out_o,
    input wire logic [2:0] pin_oe_o
);
    logic [3:0] s5_q;
    logic ack;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    assign ack = avs_read_i && !avs_waitrequest_o;
    // Shadow of the pin E5 code
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            s5_q <= 4'h0;
        else if (avs_write_i && avs_byteenable_i[0] && avs_address_i == 16'hFC14)
            s5_q <= avs_writedata_i[3:0];
    end
    // Read is held off exactly one cycle
    sequence s_rd_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    a_wr_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o) else $error("write stalled");
    a_rd_one_wait: assert property ($rose(avs_read_i) |-> s_rd_wait) else $error("read wait wrong");
    a_e5_no_conn: assert property (s5_q == 4'h0 |=> pin_out_o[0] == $past(port_latch_i[0])
        && pin_oe_o[0] == $past(port_oe_i[0])) else $error("code 0 drove pin");
    a_e5_uart3_route: assert property (s5_q == 4'h1 |=> pin_oe_o[0]
        && pin_out_o[0] == $past(uart3_request_to_send_i)) else $error("uart3 route wrong");
    a_e5_resv_none: assert property (s5_q inside {4'h5, 4'h6, 4'h9, 4'hA, 4'hC, 4'hE, 4'hF}
        |=> pin_out_o[0] == $past(port_latch_i[0])) else $error("reserved code drove pin");
    a_rd_high_zero: assert property (ack |-> avs_readdata_o[31:4] == 28'h0) else $error("upper bits set");
    a_e5_read_back: assert property (ack && avs_address_i == 16'hFC14 |-> avs_readdata_o[3:0] == s5_q)
        else $error("E5 readback wrong");
    a_unmap_resp: assert property (ack && !(avs_address_i inside {16'hFC14, 16'hFC20, 16'hFC24})
        |-> avs_response_o == 2'b10 && avs_readdata_o == 32'h0) else $error("unmapped read wrong");
endmodule
bind opsm_output_pin_select_mux opsm_asserts u_chk (.*);

//--- tb/opsm_periph_model.sv
// Model of the on-chip peripheral outputs feeding the mux
`timescale 1ns/10ps
module opsm_periph_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Peripheral outputs, first group in bits 6:0
    output logic [11:0] periph_o
);
    // Shifting pattern so a stale or wrong route shows up
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            periph_o <= 12'hA5C;
        else
            periph_o <= {periph_o[10:0], periph_o[11] ^ periph_o[5] ^ periph_o[3] ^ periph_o[0]};
    end
endmodule

//--- tb/tb_output_pin_select_mux.sv
// Testbench of the output pin select mux
`timescale 1ns/10ps
module tb_output_pin_select_mux;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
    logic [15:0] avs_address_i = 16'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rnd = 32'h54EA4096;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [2:0] port_latch_i = 3'h0, port_oe_i = 3'h0, pin_out_o, pin_oe_o;
    logic [1:0] avs_response_o;
    logic [11:0] p;
    logic [5:0] seen;
    logic [3:0] code [3] = '{default: 4'h0};
    logic [15:0] ad [4] = '{16'hFC14, 16'hFC20, 16'hFC24, 16'hFC18};
    int g1 [16] = '{-1, 0, 1, 2, -1, -1, -1, 3, 4, -1, -1, 5, -1, 6, -1, -1};
    int g2 [16] = '{-1, 7, -1, -1, 8, -1, 9, -1, -1, -1, -1, 10, 11, -1, -1, -1};
    logic [31:0] rq [$];
    logic [5:0] pq [$];
    int err_count = 0, check_count = 0;
    assign seen = {pin_oe_o[2], pin_out_o[2], pin_oe_o[1], pin_out_o[1], pin_oe_o[0], pin_out_o[0]};
    opsm_output_pin_select_mux dut (.core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
        .uart3_request_to_send_i(p[0]), .uart4_transmit_i(p[1]), .reference_clock_output_i(p[2]),
        .spi1_slave_select_i(p[3]), .spi1_serial_out_i(p[4]), .compare_output_five_i(p[5]),
        .comparator_one_output_i(p[6]), .uart2_request_to_send_i(p[7]), .uart5_transmit_i(p[8]),
        .spi2_slave_select_i(p[9]), .compare_output_two_i(p[10]), .compare_output_one_i(p[11]),
        .port_latch_i, .port_oe_i, .pin_out_o, .pin_oe_o);
    opsm_periph_model u_per (.core_clk_i, .rst_n_i, .periph_o(p));
    // Clock of 50 ns
    initial forever #25 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected {oe, out} of one pin; E8 is in the second group
    function automatic logic [1:0] rf(int i);
        int b;
        b = (i == 1) ? g2[code[i]] : g1[code[i]];
        return (b < 0) ? {port_oe_i[i], port_latch_i[i]} : {1'b1, p[b]};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Avalon-MM access held until waitrequest is sampled low
    task automatic bus(bit w, int i, logic [31:0] d, logic [3:0] be);
        @(posedge core_clk_i);
        avs_address_i <= ad[i];
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        if (!w)
            rq.push_back((i < 3) ? {28'h0, code[i]} : 32'h0);
        repeat (20) begin
            @(posedge core_clk_i);
            if (avs_waitrequest_o === 1'b0)
                break;
        end
        if (w && i < 3 && be[0])
            code[i] = d[3:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    // Random port latch and direction every cycle
    always @(posedge core_clk_i) begin
        rnd <= lfsr(rnd);
        port_latch_i <= rnd[2:0];
        port_oe_i <= rnd[5:3];
    end
    // Note the pin drive due after the coming edge
    always @(negedge core_clk_i) begin
        if (rst_n_i)
            pq.push_back({rf(2), rf(1), rf(0)});
    end
    // Compare read data and pin drive with the oldest notes
    always @(posedge core_clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0 && rq.size() > 0) begin
            chk("readdata", avs_readdata_o, rq.pop_front());
            chk("response", 32'(avs_response_o), (avs_address_i == 16'hFC18) ? 32'h2 : 32'h0);
        end
        #1;
        if (pq.size() > 0)
            chk("pins", 32'(seen), 32'(pq.pop_front()));
    end
    // Reset values, every code on every pin, ignored writes
    initial begin
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++)
            bus(1'b0, i, 32'h0, 4'h0);
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 16; c++) begin
                bus(1'b1, i, {rnd[31:4], 4'(c)}, 4'hF);
                repeat (3) @(posedge core_clk_i);
                bus(1'b0, i, 32'h0, 4'h0);
            end
        end
        bus(1'b1, 0, 32'h5, 4'hE);
        bus(1'b1, 3, 32'h7, 4'hF);
        bus(1'b0, 0, 32'h0, 4'h0);
        bus(1'b0, 3, 32'h0, 4'h0);
        repeat (3) @(posedge core_clk_i);
        stop_test();
    end
    // Watchdog far beyond the expected run length
    initial begin
        #1000000;
        err_count++;
        stop_test();
    end
endmodule
